// *** rtl/bnc_pkg.sv ***
package bnc_pkg;
  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] BNC_ADDR_EVENT_FLAGS = 8'h33;
  localparam logic [7:0] BNC_ADDR_MEM_CMD     = 8'h34;
  localparam logic [7:0] BNC_RESET_EVENT      = 8'h04;
  localparam logic [7:0] BNC_RESET_CMD        = 8'h00;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int BNC_BIT_PRESS    = 0;
  localparam int BNC_BIT_RELEASE  = 1;
  localparam int BNC_BIT_LEVEL    = 2;
  localparam int BNC_BIT_SLEEPTO  = 3;
  localparam int BNC_BIT_OSC      = 4;
  localparam int BNC_BIT_PROGDONE = 5;
  localparam int BNC_BIT_VERDONE  = 6;
  localparam int BNC_BIT_VERERR   = 7;

  // ****************************************************
  // Command codes
  // ****************************************************
  localparam logic [3:0] BNC_CMD_OSC_RELEASE = 4'h6;
  localparam logic [3:0] BNC_CMD_VERIFY      = 4'h7;
  localparam logic [3:0] BNC_CMD_OSC_FORCE   = 4'h9;
  localparam logic [3:0] BNC_CMD_PROGRAM     = 4'hA;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int BNC_CLK_MHZ       = 100;
  localparam int BNC_FILTER_MS     = 64;
  localparam int BNC_FILTER_CYCLES = BNC_FILTER_MS * 1000 * BNC_CLK_MHZ;
endpackage : bnc_pkg

// *** rtl/bnc_button_nvm_regs.sv ***
`timescale 1ns/1ps
// Functional notes
// - Set sleep-exit-timeout flag on wake timeout.
// - Live filtered button level, reset one.
// - Latch release after filter; drives irq.
// - Latch press after filter; drives irq.
// - Set verify-done after verify; clear W1C.
// - Set program-done after program; clear W1C.
// - Verify-error shows result; clear W1C.
// - Code 9h forces oscillator, status set.
// - Codes 7h/Ah start verify/program when not busy.
// - Command field always reads zero.
module bnc_button_nvm_regs #(
  parameter int FILTER_CYCLES = bnc_pkg::BNC_FILTER_CYCLES
) (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic       i_button_n,
  input  wire logic       i_button_mode,
  input  wire logic       i_sleep_exit_timeout,
  input  wire logic       i_button_irq_mask,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_write,
  input  wire logic       i_reg_read,
  input  wire logic       i_mem_busy,
  input  wire logic       i_verify_finished,
  input  wire logic       i_verify_failed,
  input  wire logic       i_program_finished,
  output logic      [7:0] o_reg_rdata,
  output logic            o_irq_out_n,
  output logic            o_verify_start,
  output logic            o_program_start,
  output logic            o_osc_force_on
);
  import bnc_pkg::*;

  // ****************************************************
  // Button filter
  // ****************************************************
  logic [31:0] filt_cnt_reg;
  logic        level_reg;
  logic        press_reg;
  logic        release_reg;
  logic        sleepto_reg;
  logic        press_evt;
  logic        release_evt;
  logic        wr_flags;
  logic        wr_cmd;
  logic        rd_any;
  logic [3:0]  cmd;

  // Shared by the write strobes and the read mux
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] target);
    return addr == target;
  endfunction : addr_hit

  assign wr_flags = i_reg_write && addr_hit(i_reg_addr, BNC_ADDR_EVENT_FLAGS);
  assign wr_cmd   = i_reg_write && addr_hit(i_reg_addr, BNC_ADDR_MEM_CMD);
  assign rd_any   = i_reg_read;
  assign cmd      = i_reg_wdata[3:0];

  // Filtered level only updates after the raw pin has held a new value
  // for the whole window, so bounces never reach the flags.
  assign press_evt   = i_button_mode && level_reg && !i_button_n
                       && (filt_cnt_reg == 32'(FILTER_CYCLES - 1));
  assign release_evt = i_button_mode && !level_reg && i_button_n
                       && (filt_cnt_reg == 32'(FILTER_CYCLES - 1));

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      filt_cnt_reg <= 32'h0;
    end else if (!i_button_mode || (i_button_n == level_reg)) begin
      filt_cnt_reg <= 32'h0;
    end else if (press_evt || release_evt) begin
      filt_cnt_reg <= 32'h0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_reg <= BNC_RESET_EVENT[BNC_BIT_LEVEL];
    end else if (press_evt) begin
      level_reg <= 1'b0;
    end else if (release_evt) begin
      level_reg <= 1'b1;
    end
  end

  // ****************************************************
  // Sticky event flags, set wins over clear
  // ****************************************************
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      press_reg   <= 1'b0;
      release_reg <= 1'b0;
      sleepto_reg <= 1'b0;
    end else begin
      press_reg   <= press_evt
                     || (press_reg
                         && !(wr_flags && i_reg_wdata[BNC_BIT_PRESS]));
      release_reg <= release_evt
                     || (release_reg
                         && !(wr_flags && i_reg_wdata[BNC_BIT_RELEASE]));
      sleepto_reg <= i_sleep_exit_timeout
                     || (sleepto_reg
                         && !(wr_flags && i_reg_wdata[BNC_BIT_SLEEPTO]));
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq_out_n <= 1'b1;
    end else begin
      o_irq_out_n <= !(!i_button_irq_mask
                       && (press_reg || release_reg));
    end
  end

  // ****************************************************
  // Memory command register
  // ****************************************************
  logic verr_reg;
  logic vdone_reg;
  logic pdone_reg;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_verify_start  <= 1'b0;
      o_program_start <= 1'b0;
    end else begin
      // Verify and program commands while the array is busy are dropped, not queued.
      o_verify_start  <= wr_cmd && !i_mem_busy
                         && (cmd == BNC_CMD_VERIFY);
      o_program_start <= wr_cmd && !i_mem_busy
                         && (cmd == BNC_CMD_PROGRAM);
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_osc_force_on <= 1'b0;
    end else if (wr_cmd && cmd == BNC_CMD_OSC_FORCE) begin
      o_osc_force_on <= 1'b1;
    end else if (wr_cmd && cmd == BNC_CMD_OSC_RELEASE) begin
      o_osc_force_on <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      verr_reg  <= 1'b0;
      vdone_reg <= 1'b0;
      pdone_reg <= 1'b0;
    end else begin
      if (i_verify_finished) begin
        verr_reg <= i_verify_failed;
      end else if (wr_cmd && i_reg_wdata[BNC_BIT_VERERR]) begin
        verr_reg <= 1'b0;
      end
      vdone_reg <= i_verify_finished
                   || (vdone_reg
                       && !(wr_cmd && i_reg_wdata[BNC_BIT_VERDONE]));
      pdone_reg <= i_program_finished
                   || (pdone_reg
                       && !(wr_cmd && i_reg_wdata[BNC_BIT_PROGDONE]));
    end
  end

  // ****************************************************
  // Read data
  // ****************************************************
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (rd_any && addr_hit(i_reg_addr, BNC_ADDR_EVENT_FLAGS)) begin
      o_reg_rdata <= {4'h0, sleepto_reg, level_reg, release_reg, press_reg};
    end else if (rd_any && addr_hit(i_reg_addr, BNC_ADDR_MEM_CMD)) begin
      o_reg_rdata <= {verr_reg, vdone_reg, pdone_reg, o_osc_force_on,
                      4'h0};
    end else if (rd_any) begin
      o_reg_rdata <= 8'h00;
    end
  end
endmodule : bnc_button_nvm_regs

// *** sim/bnc_mem_model.sv ***
`timescale 1ns/1ps
module bnc_mem_model (
  input  wire logic i_clock,
  input  wire logic i_verify_start,
  input  wire logic i_program_start,
  input  wire logic i_fail,
  output logic      o_busy,
  output logic      o_verify_done,
  output logic      o_failed,
  output logic      o_program_done
);
  logic [3:0] cnt_reg  = 4'h0;
  logic       prog_reg = 1'b0;
  assign o_busy = cnt_reg != 4'h0;
  assign o_verify_done = cnt_reg == 4'h1 && !prog_reg;
  assign o_program_done = cnt_reg == 4'h1 && prog_reg;
  // Result only meaningful with the finish pulse; inverted otherwise
  assign o_failed = o_verify_done ? i_fail : !i_fail;
  always_ff @(posedge i_clock) begin
    if (i_verify_start || i_program_start) begin
      cnt_reg  <= 4'h6;
      prog_reg <= i_program_start;
    end else if (o_busy) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule : bnc_mem_model

// *** sim/bnc_regs_assertions.sv ***
`timescale 1ns/1ps
module bnc_regs_checker (
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_write,
  input wire logic       i_reg_read,
  input wire logic       i_mem_busy,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_verify_start,
  input wire logic       o_program_start,
  input wire logic       o_osc_force_on
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_cmd(logic [3:0] c);
    i_reg_write && i_reg_addr == 8'h34 && i_reg_wdata[3:0] == c;
  endsequence
  sequence s_go(logic [3:0] c);
    s_cmd(c) ##0 !i_mem_busy;
  endsequence
  property p_vs; s_go(4'h7) |=> o_verify_start; endproperty
  property p_ps; s_go(4'hA) |=> o_program_start; endproperty
  property p_nb; s_cmd(4'h7) ##0 i_mem_busy |=> !o_verify_start; endproperty
  property p_vp; o_verify_start |=> !o_verify_start; endproperty
  property p_pp; o_program_start |=> !o_program_start; endproperty
  property p_fo; s_cmd(4'h9) |=> o_osc_force_on; endproperty
  property p_fr; s_cmd(4'h6) |=> !o_osc_force_on; endproperty
  property p_cz; i_reg_read && i_reg_addr == 8'h34 |=> !(|o_reg_rdata[3:0]);
  endproperty
  a_vs: assert property (p_vs) else $error("verify not started");
  a_ps: assert property (p_ps) else $error("program not started");
  a_nb: assert property (p_nb) else $error("start while busy");
  a_vp: assert property (p_vp) else $error("verify pulse long");
  a_pp: assert property (p_pp) else $error("program pulse long");
  a_fo: assert property (p_fo) else $error("osc not forced");
  a_fr: assert property (p_fr) else $error("osc not released");
  a_cz: assert property (p_cz) else $error("command field nonzero");
endmodule : bnc_regs_checker
bind bnc_button_nvm_regs bnc_regs_checker u_chk (.*);

// *** sim/bnc_button_nvm_regs_test.sv ***
`timescale 1ns/1ps
module bnc_button_nvm_regs_test;
  import bnc_pkg::*;
  logic       clk = 0, rst_n = 0, btn_n = 1, slp = 0, mask = 0;
  logic       wr_s = 0, rd_s = 0, fail = 0, mode = 1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic       irq_n, vs, ps, osc, busy, vf, vfl, pf;
  int         n_errors = 0, checks_done = 0;
  bnc_button_nvm_regs #(.FILTER_CYCLES(8)) u_dut (
    .i_clock(clk), .i_reset_n(rst_n), .i_button_n(btn_n),
    .i_button_mode(mode), .i_sleep_exit_timeout(slp),
    .i_button_irq_mask(mask), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_write(wr_s), .i_reg_read(rd_s), .i_mem_busy(busy),
    .i_verify_finished(vf), .i_verify_failed(vfl),
    .i_program_finished(pf), .o_reg_rdata(rdata), .o_irq_out_n(irq_n),
    .o_verify_start(vs), .o_program_start(ps), .o_osc_force_on(osc));
  bnc_mem_model u_mem (.i_clock(clk), .i_verify_start(vs),
    .i_program_start(ps), .i_fail(fail), .o_busy(busy),
    .o_verify_done(vf), .o_failed(vfl), .o_program_done(pf));
  task automatic chk(input logic [7:0] got, exp, input string nm);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk) {addr, wd, wr_s} = {a, d, 1'b1};
    @(negedge clk) wr_s = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk) {addr, rd_s} = {a, 1'b1};
    @(negedge clk) rd_s = 1'b0;
    chk(rdata, exp, "rdata");
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  initial forever #5 clk = ~clk;
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    rd(8'h33, 8'h04);
    rd(8'h34, 8'h00);
    // Glitch shorter than the filter must not move the level
    btn_n = 0;
    repeat (4) @(negedge clk);
    btn_n = 1;
    rd(8'h33, 8'h04);
    btn_n = 0;
    repeat (12) @(negedge clk);
    chk({7'h00, irq_n}, 8'h00, "irq_n");
    rd(8'h33, 8'h01);
    wr(8'h33, 8'h02);
    rd(8'h33, 8'h01);
    wr(8'h33, 8'h01);
    rd(8'h33, 8'h00);
    chk({7'h00, irq_n}, 8'h01, "irq_n");
    {mask, btn_n} = 2'b11;
    repeat (12) @(negedge clk);
    chk({7'h00, irq_n}, 8'h01, "irq_n");
    rd(8'h33, 8'h06);
    mask = 0;
    repeat (2) @(negedge clk);
    chk({7'h00, irq_n}, 8'h00, "irq_n");
    wr(8'h33, 8'h02);
    @(negedge clk) slp = 1;
    @(negedge clk) slp = 0;
    rd(8'h33, 8'h0C);
    wr(8'h33, 8'h08);
    rd(8'h33, 8'h04);
    // Outside button configuration a long press must leave no trace
    {mode, btn_n} = 2'b00;
    repeat (12) @(negedge clk);
    rd(8'h33, 8'h04);
    {mode, btn_n} = 2'b11;
    $display("button tests done");
    wr(8'h34, 8'h09);
    chk({7'h00, osc}, 8'h01, "osc");
    rd(8'h34, 8'h10);
    wr(8'h34, 8'h06);
    rd(8'h34, 8'h00);
    wr(8'h34, 8'h07);
    repeat (2) @(negedge clk);
    // Program code arrives while the array is still busy
    wr(8'h34, 8'h0A);
    repeat (10) @(negedge clk);
    rd(8'h34, 8'h40);
    wr(8'h34, 8'h40);
    fail = 1;
    wr(8'h34, 8'h07);
    repeat (10) @(negedge clk);
    rd(8'h34, 8'hC0);
    wr(8'h34, 8'hC0);
    fail = 0;
    wr(8'h34, 8'h0A);
    repeat (10) @(negedge clk);
    rd(8'h34, 8'h20);
    wr(8'h34, 8'h20);
    rd(8'h34, 8'h00);
    rd(8'h35, 8'h00);
    $display("command tests done");
    report_and_stop();
  end
endmodule : bnc_button_nvm_regs_test
